// ---- rtl/clk_out_gate.v ----
// One clock output pair with its disable levels.
`timescale 1ns/10ps
module clk_out_gate (
    input  wire clk,
    input  wire rst,
    input  wire enable,
    input  wire clk_src,
    input  wire single_ended,
    input  wire same_phase,
    output reg  true_q,
    output reg  comp_q
);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            true_q <= 1'b0;
            comp_q <= 1'b1;
        end else if (enable) begin
            true_q <= clk_src;
            comp_q <= ~clk_src;
        end else begin
            true_q <= 1'b0;
            comp_q <= ~(single_ended & same_phase);
        end
    end
endmodule

// ---- rtl/master_reset_controller.v ----
// Master reset controller: power-on reset, reset sequence, outputs.
`timescale 1ns/10ps
`include "mrst_map.vh"
module master_reset_controller #(
    parameter POR_CYCLES = `POR_DELAY_CYC
) (
    // Clock and reset.
    input  wire                                 CLK_IN,
    input  wire                                 RESET_IN,
    // Supplies and reset pin.
    input  wire                                 SUPPLY_GOOD_IN,
    input  wire                                 MASTER_RESET_LOW_PIN_IN,
    // Configuration.
    input  wire                                 EEPROM_MODE_IN,
    input  wire                                 LOAD_DONE_IN,
    input  wire [`NUM_OUTS*`STARTUP_W-1:0]      OUT_STARTUP_IN,
    input  wire [`NUM_OUTS-1:0]                 SINGLE_ENDED_IN,
    input  wire [`NUM_OUTS-1:0]                 SAME_PHASE_IN,
    input  wire [`NUM_OUTS-1:0]                 CLK_SRC_IN,
    input  wire [`NUM_GPIO*`GPIO_FUNC_W-1:0]    GPIO_FUNC_IN,
    input  wire                                 RST_DONE_CLR_IN,
    // Status and outputs.
    output reg                                  POR_OUT,
    output reg                                  LOAD_START_OUT,
    output reg                                  LOAD_FROM_EEPROM_OUT,
    output reg                                  DEVICE_READY_OUT,
    output reg                                  RST_DONE_OUT,
    output reg  [`NUM_GPIO-1:0]                 GPIO_READY_OUT,
    output wire [`NUM_OUTS-1:0]                 CLOCK_OUT_TRUE_OUT,
    output wire [`NUM_OUTS-1:0]                 CLOCK_OUT_COMPLEMENT_OUT
);
    reg        sup_m_q;
    reg        sup_s_q;
    reg        pin_m_q;
    reg        pin_s_q;
    reg        pin_d1_q;
    reg [27:0] por_cnt_q;
    reg [2:0]  state_q;
    reg [6:0]  step_cnt_q;
    reg [`STARTUP_W:0] phase_q;
    reg [`NUM_OUTS-1:0] en_q;
    wire       pin_rise = pin_s_q & ~pin_d1_q;
    integer    i;

    // Two-flop synchronisers for the supply flag and the reset pin.
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            sup_m_q  <= 1'b0;
            sup_s_q  <= 1'b0;
            pin_m_q  <= 1'b1;
            pin_s_q  <= 1'b1;
            pin_d1_q <= 1'b1;
        end else begin
            sup_m_q  <= SUPPLY_GOOD_IN;
            sup_s_q  <= sup_m_q;
            pin_m_q  <= MASTER_RESET_LOW_PIN_IN;
            pin_s_q  <= pin_m_q;
            pin_d1_q <= pin_s_q;
        end
    end

    // Power-on reset delay counter.
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            por_cnt_q <= 28'h0;
            POR_OUT   <= 1'b0;
        end else if (!sup_s_q) begin
            por_cnt_q <= 28'h0;
            POR_OUT   <= 1'b0;
        end else if (por_cnt_q >= POR_CYCLES[27:0] - 28'h1) begin
            POR_OUT <= 1'b1;
        end else begin
            por_cnt_q <= por_cnt_q + 28'h1;
        end
    end

    // Sequence state machine.
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state_q              <= `ST_IDLE;
            step_cnt_q           <= 7'h0;
            phase_q              <= 3'h0;
            LOAD_START_OUT       <= 1'b0;
            LOAD_FROM_EEPROM_OUT <= 1'b0;
            DEVICE_READY_OUT     <= 1'b0;
            RST_DONE_OUT         <= 1'b0;
        end else begin
            LOAD_START_OUT <= 1'b0;
            if (RST_DONE_CLR_IN) begin
                RST_DONE_OUT <= 1'b0;
            end
            if (!POR_OUT) begin
                state_q          <= `ST_IDLE;
                DEVICE_READY_OUT <= 1'b0;
            end else begin
                case (state_q)
                    `ST_IDLE: begin
                        if (pin_s_q) begin
                            state_q <= `ST_DISABLE;
                        end else begin
                            state_q <= `ST_WAIT_HIGH;
                        end
                    end
                    `ST_WAIT_HIGH: begin
                        if (pin_rise) begin
                            state_q <= `ST_DISABLE;
                        end
                    end
                    `ST_DISABLE: begin
                        DEVICE_READY_OUT <= 1'b0;
                        phase_q          <= 3'h0;
                        step_cnt_q       <= 7'h0;
                        state_q          <= `ST_STARTUP;
                    end
                    `ST_STARTUP: begin
                        if (step_cnt_q == `STEP_CYC - 1) begin
                            step_cnt_q <= 7'h0;
                            phase_q    <= phase_q + 3'h1;
                            if (phase_q == 3'h3) begin
                                state_q              <= `ST_LOAD;
                                LOAD_START_OUT       <= 1'b1;
                                LOAD_FROM_EEPROM_OUT <= EEPROM_MODE_IN;
                            end
                        end else begin
                            step_cnt_q <= step_cnt_q + 7'h1;
                        end
                    end
                    `ST_LOAD: begin
                        if (LOAD_FROM_EEPROM_OUT ? LOAD_DONE_IN
                            : (step_cnt_q == `LOAD_CYC - 1)) begin
                            state_q          <= `ST_DONE;
                            DEVICE_READY_OUT <= 1'b1;
                            RST_DONE_OUT     <= 1'b1;
                        end else begin
                            step_cnt_q <= step_cnt_q + 7'h1;
                        end
                    end
                    `ST_DONE: begin
                        if (pin_rise) begin
                            state_q <= `ST_DISABLE;
                        end
                    end
                    default: state_q <= `ST_IDLE;
                endcase
                // A pulse during a running sequence restarts it.
                if (pin_rise && (state_q == `ST_STARTUP ||
                                 state_q == `ST_LOAD)) begin
                    state_q <= `ST_DISABLE;
                end
            end
        end
    end

    // Per-output enables follow the startup phase.
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            en_q <= {`NUM_OUTS{1'b0}};
        end else begin
            for (i = 0; i < `NUM_OUTS; i = i + 1) begin
                if (state_q == `ST_STARTUP || state_q == `ST_LOAD ||
                    state_q == `ST_DONE)
                    en_q[i] <= (state_q != `ST_STARTUP) ||
                        ({1'b0, OUT_STARTUP_IN[i*`STARTUP_W +: `STARTUP_W]}
                         < phase_q);
                else
                    en_q[i] <= 1'b0;
            end
        end
    end

    // GPIO mirrors of the ready bit.
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            GPIO_READY_OUT <= {`NUM_GPIO{1'b0}};
        end else begin
            for (i = 0; i < `NUM_GPIO; i = i + 1) begin
                GPIO_READY_OUT[i] <=
                    (GPIO_FUNC_IN[i*`GPIO_FUNC_W +: `GPIO_FUNC_W] ==
                     `GPIO_FUNC_READY) & DEVICE_READY_OUT;
            end
        end
    end

    // Output gates, one per clock output pair.
    genvar g;
    generate
        for (g = 0; g < `NUM_OUTS; g = g + 1) begin : outs
            clk_out_gate u_gate (
                .clk          (CLK_IN),
                .rst          (RESET_IN),
                .enable       (en_q[g]),
                .clk_src      (CLK_SRC_IN[g]),
                .single_ended (SINGLE_ENDED_IN[g]),
                .same_phase   (SAME_PHASE_IN[g]),
                .true_q       (CLOCK_OUT_TRUE_OUT[g]),
                .comp_q       (CLOCK_OUT_COMPLEMENT_OUT[g])
            );
        end
    endgenerate
endmodule

// ---- rtl/mrst_map.vh ----
// Constants of the master reset controller.
`ifndef MRST_MAP_VH
`define MRST_MAP_VH
`define CLK_PERIOD_NS     100
`define POR_DELAY_MS      20
`define POR_DELAY_CYC     ((`POR_DELAY_MS * 1000000) / `CLK_PERIOD_NS)
`define NUM_OUTS          12
`define NUM_GPIO          4
`define GPIO_FUNC_W       5
`define GPIO_FUNC_READY   5'h18
`define STARTUP_W         2
`define STEP_CYC          16
`define LOAD_CYC          64
`define ST_IDLE           3'h0
`define ST_WAIT_HIGH      3'h1
`define ST_DISABLE        3'h2
`define ST_STARTUP        3'h3
`define ST_LOAD           3'h4
`define ST_DONE           3'h5
`endif

// ---- verif/host_model.sv ----
// Host model: answers an EEPROM load after a set delay.
`timescale 1ns/10ps
module host_model (
    input  wire       clk_in,
    input  wire       rst_in,
    input  wire       load_start_in,
    input  wire       eeprom_in,
    input  wire       ready_in,
    input  wire [7:0] delay_in,
    output reg        load_done_out
);
    reg [7:0] wait_q;
    reg       busy_q;
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_q        <= 8'h00;
            busy_q        <= 1'b0;
            load_done_out <= 1'b0;
        end else if (load_start_in) begin
            wait_q        <= delay_in;
            busy_q        <= 1'b1;
            load_done_out <= 1'b0;
        end else if (wait_q != 8'h00)
            wait_q <= wait_q - 8'h01;
        else begin
            busy_q        <= busy_q & !ready_in;
            load_done_out <= busy_q & eeprom_in & !ready_in;
        end
    end
endmodule

// ---- verif/master_reset_controller_tb.sv ----
// Testbench of the master reset controller.
`timescale 1ns/10ps
`include "mrst_map.vh"
module master_reset_controller_tb;
    reg         clk = 1'b0, rst = 1'b1, supply = 1'b0, eeprom = 1'b0;
    reg         master_reset_low_pin = 1'b1, clr = 1'b0;
    reg  [11:0] clk_src = 12'hfff, same_phase = 12'h005;
    wire        por, lstart, from_ee, ready, done, load_done;
    wire [3:0]  gpio;
    wire [11:0] o_true, o_comp;
    integer     error_cnt = 0, checked = 0, cyc = 0, i;
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            error_cnt = error_cnt + 1;
            results;
        end
    end
    master_reset_controller #(.POR_CYCLES(20)) u_dut (
        .CLK_IN(clk), .RESET_IN(rst), .SUPPLY_GOOD_IN(supply),
        .MASTER_RESET_LOW_PIN_IN(master_reset_low_pin),
        .EEPROM_MODE_IN(eeprom), .LOAD_DONE_IN(load_done),
        .OUT_STARTUP_IN(24'hc00000), .SINGLE_ENDED_IN(12'h00f),
        .SAME_PHASE_IN(same_phase), .CLK_SRC_IN(clk_src),
        .GPIO_FUNC_IN(20'h00018), .RST_DONE_CLR_IN(clr), .POR_OUT(por),
        .LOAD_START_OUT(lstart), .LOAD_FROM_EEPROM_OUT(from_ee),
        .DEVICE_READY_OUT(ready), .RST_DONE_OUT(done), .GPIO_READY_OUT(gpio),
        .CLOCK_OUT_TRUE_OUT(o_true), .CLOCK_OUT_COMPLEMENT_OUT(o_comp));
    host_model u_host (.clk_in(clk), .rst_in(rst), .load_start_in(lstart),
        .eeprom_in(from_ee), .ready_in(ready), .delay_in(8'h96),
        .load_done_out(load_done));
    task chk(input ok, input [8*20-1:0] msg);
        begin
            checked = checked + 1;
            if (!ok) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0t %0s", $time, msg);
            end
        end
    endtask
    task pulse;
        begin
            master_reset_low_pin = 1'b0;
            repeat (2) @(negedge clk);
            master_reset_low_pin = 1'b1;
        end
    endtask
    task wait_on(input integer n, input integer k);
        for (i = 0; i < n && (k ? o_true[0] : ready) !== 1'b1; i = i + 1)
            @(negedge clk);
    endtask
    task t_power;
        begin
            supply = 1'b1;
            repeat (19) @(negedge clk);
            chk(por === 1'b0, "por early");
            chk(o_true === 12'h000 &&
                o_comp === 12'hffa, "off levels");
            repeat (6) @(negedge clk);
            chk(por === 1'b1, "por late");
            wait_on(200, 0);
            chk(ready === 1'b1 && done === 1'b1, "no ready");
            @(negedge clk);
            chk(gpio === 4'h1, "gpio mirror");
            $display("power test over");
        end
    endtask
    task t_restart;
        begin
            clr = 1'b1;
            @(negedge clk);
            clr = 1'b0;
            chk(done === 1'b0, "done kept");
            pulse;
            repeat (8) @(negedge clk);
            chk(o_true === 12'h000 && ready === 1'b0, "not off");
            wait_on(40, 1);
            chk(o_true[0] === 1'b1 && o_true[11] === 1'b0, "order");
            pulse;
            repeat (8) @(negedge clk);
            chk(o_true[0] === 1'b0, "no restart");
            wait_on(200, 0);
            chk((ready & done & (&o_true)) === 1'b1, "restart");
            clk_src = 12'h0f0;
            repeat (2) @(negedge clk);
            chk(o_true === 12'h0f0, "outs not following");
            clk_src = 12'hfff;
            $display("restart test over");
        end
    endtask
    task t_defer;
        begin
            rst = 1'b1;
            supply = 1'b0;
            master_reset_low_pin = 1'b0;
            @(negedge clk);
            rst = 1'b0;
            supply = 1'b1;
            repeat (120) @(negedge clk);
            chk(por === 1'b1 && ready === 1'b0 &&
                lstart === 1'b0, "no defer");
            same_phase = 12'h00f;
            repeat (2) @(negedge clk);
            chk(o_comp === 12'hff0, "same phase level");
            master_reset_low_pin = 1'b1;
            wait_on(200, 0);
            chk(ready === 1'b1, "deferred start");
            $display("defer test over");
        end
    endtask
    task t_eeprom;
        begin
            eeprom = 1'b1;
            pulse;
            for (i = 0; i < 100 && lstart !== 1'b1; i = i + 1)
                @(negedge clk);
            chk(lstart === 1'b1, "no load start");
            repeat (100) @(negedge clk);
            chk(from_ee === 1'b1 && ready === 1'b0, "ready early");
            wait_on(100, 0);
            chk(ready === 1'b1 && done === 1'b1, "eeprom load");
            $display("eeprom test over");
        end
    endtask
    task results;
        begin
            $display("checked %0d errors %0d", checked, error_cnt);
            if (error_cnt == 0 && checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_power;
        t_restart;
        t_defer;
        t_eeprom;
        results;
    end
endmodule
bind master_reset_controller mrst_checker #(.POR_CYCLES(POR_CYCLES)) u_chk (
    .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .SUPPLY_GOOD_IN(SUPPLY_GOOD_IN),
    .LOAD_DONE_IN(LOAD_DONE_IN), .CLK_SRC_IN(CLK_SRC_IN),
    .GPIO_FUNC_IN(GPIO_FUNC_IN), .POR_OUT(POR_OUT),
    .LOAD_START_OUT(LOAD_START_OUT),
    .LOAD_FROM_EEPROM_OUT(LOAD_FROM_EEPROM_OUT),
    .DEVICE_READY_OUT(DEVICE_READY_OUT), .RST_DONE_OUT(RST_DONE_OUT),
    .GPIO_READY_OUT(GPIO_READY_OUT), .CLOCK_OUT_TRUE_OUT(CLOCK_OUT_TRUE_OUT));

// ---- verif/mrst_checker.sv ----
// Port checker of the master reset controller.
`timescale 1ns/10ps
`include "mrst_map.vh"
module mrst_checker #(
    parameter POR_CYCLES = 20
) (
    input wire                 CLK_IN,
    input wire                 RESET_IN,
    input wire                 SUPPLY_GOOD_IN,
    input wire                 LOAD_DONE_IN,
    input wire [`NUM_OUTS-1:0] CLK_SRC_IN,
    input wire [19:0]          GPIO_FUNC_IN,
    input wire                 POR_OUT,
    input wire                 LOAD_START_OUT,
    input wire                 LOAD_FROM_EEPROM_OUT,
    input wire                 DEVICE_READY_OUT,
    input wire                 RST_DONE_OUT,
    input wire [3:0]           GPIO_READY_OUT,
    input wire [`NUM_OUTS-1:0] CLOCK_OUT_TRUE_OUT
);
    reg [31:0] sup_q;
    always @(posedge CLK_IN or posedge RESET_IN)
        if (RESET_IN)
            sup_q <= 32'h0;
        else if (!SUPPLY_GOOD_IN)
            sup_q <= 32'h0;
        else if (sup_q < 32'hffff)
            sup_q <= sup_q + 32'h1;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    chk_por_early: assert property (
        $rose(POR_OUT) |-> sup_q >= POR_CYCLES) else $error("por early");
    chk_off_level: assert property (
        !POR_OUT && !$past(RESET_IN) |-> CLOCK_OUT_TRUE_OUT == 0)
        else $error("output not disabled");
    chk_ready_done: assert property (
        $rose(DEVICE_READY_OUT) |-> RST_DONE_OUT) else $error("no done");
    chk_gpio_mirror: assert property (GPIO_READY_OUT[0] ==
        ($past(DEVICE_READY_OUT) && $past(GPIO_FUNC_IN[4:0]) == 5'h18))
        else $error("gpio mirror wrong");
    chk_load_pulse: assert property (
        LOAD_START_OUT |=> !LOAD_START_OUT) else $error("long load pulse");
    chk_eeprom_wait: assert property (
        $rose(DEVICE_READY_OUT) && LOAD_FROM_EEPROM_OUT |-> $past(LOAD_DONE_IN))
        else $error("ready before load done");
    chk_outs_follow: assert property (
        DEVICE_READY_OUT && $past(DEVICE_READY_OUT) |->
        CLOCK_OUT_TRUE_OUT == $past(CLK_SRC_IN)) else $error("outputs off");
    chk_ready_drop: assert property (
        LOAD_START_OUT |-> !DEVICE_READY_OUT) else $error("stale ready");
    cover property ($rose(DEVICE_READY_OUT));
    cover property ($rose(DEVICE_READY_OUT) && LOAD_FROM_EEPROM_OUT);
    cover property ($rose(GPIO_READY_OUT[0]));
endmodule
